// ---- obs_pkg.sv ----
package obs_pkg;
  // register map, one 32-bit word each
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CW_LIM = 8'h04;
  localparam logic [7:0] OFF_CCW_LIM = 8'h08;
  localparam logic [7:0] OFF_HYS = 8'h0C;
  localparam logic [7:0] OFF_REL_DLY = 8'h10;
  localparam logic [7:0] OFF_APP_DLY = 8'h14;
  localparam logic [7:0] OFF_CON_DLY = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  // control bits
  localparam int CTRL_FUNC_BIT = 0;
  localparam int CTRL_CONT_BIT = 1;
  // values after reset
  localparam logic [15:0] RST_CW_LIM = 16'h005A;
  localparam logic [15:0] RST_CCW_LIM = 16'hFFA6;
  localparam logic [15:0] RST_HYS = 16'h002D;
  localparam logic [15:0] RST_REL_DLY = 16'h0064;
  localparam logic [15:0] RST_APP_DLY = 16'h0064;
  localparam logic [15:0] RST_CON_DLY = 16'h000A;
  // setting ranges
  localparam logic [15:0] LIM_MAX = 16'h7FFC;
  localparam logic [15:0] LIM_MIN = 16'h8004;
  localparam logic [15:0] HYS_MIN = 16'h0001;
  // millisecond tick
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_MS = 1;
  localparam int CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
  localparam int DIV_W = 17;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CON_ON = 3'b001,
    ST_RELEASE = 3'b010,
    ST_RUN = 3'b011,
    ST_DECEL = 3'b100,
    ST_APPLY = 3'b101,
    ST_LOW = 3'b110,
    ST_CON_OFF = 3'b111
  } obs_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } obs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } obs_apb_rsp_t;

  typedef struct packed {
    logic brake_release;
    logic power_stage_en;
    logic contactor_on;
    logic [15:0] speed_setpoint;
  } obs_drive_t;
endpackage

// ---- obs_brake_seq.sv ----
`timescale 1ns/1ps
module obs_brake_seq
  import obs_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = CYC_PER_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire obs_apb_req_t apb_req,
  output obs_apb_rsp_t apb_rsp,
  input wire logic [15:0] speed_cmd,
  input wire logic [15:0] speed_act,
  input wire logic fault,
  output obs_drive_t drive
);

  typedef struct packed {
    obs_state_t st;
    logic dir_ccw;
    logic func_en;
    logic cont_en;
    logic [15:0] cw_lim;
    logic [15:0] ccw_lim;
    logic [15:0] hys;
    logic [15:0] rel_dly;
    logic [15:0] app_dly;
    logic [15:0] con_dly;
    logic [15:0] cnt;
    logic [DIV_W-1:0] div;
    logic tick;
    logic brake;
    logic pwr;
    logic con;
    logic [15:0] sp;
    logic [31:0] prdata;
  } obs_regs_t;

  obs_regs_t s_q;
  obs_regs_t s_d;

  function automatic logic signed [17:0] sx(input logic [15:0] v);
    sx = {{2{v[15]}}, v};
  endfunction

  logic signed [17:0] cmd_w;
  logic signed [17:0] act_w;
  logic signed [17:0] cw_w;
  logic signed [17:0] ccw_w;
  logic signed [17:0] hys_w;
  logic exceed_cw;
  logic exceed_ccw;
  logic below;
  logic reached;
  logic [15:0] lim;
  logic cmd_zero;
  logic dly_done;
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic locked;
  logic [31:0] rd_data;

  assign cmd_w = sx(speed_cmd);
  assign act_w = sx(speed_act);
  assign cw_w = sx(s_q.cw_lim);
  assign ccw_w = sx(s_q.ccw_lim);
  assign hys_w = sx(s_q.hys);
  assign exceed_cw = cmd_w > (cw_w + hys_w);
  assign exceed_ccw = cmd_w < (ccw_w - hys_w);
  assign below = s_q.dir_ccw ? (cmd_w > ccw_w) : (cmd_w < cw_w);
  assign reached = s_q.dir_ccw ? (act_w >= ccw_w) : (act_w <= cw_w);
  assign lim = s_q.dir_ccw ? s_q.ccw_lim : s_q.cw_lim;
  assign cmd_zero = speed_cmd == 16'h0000;
  assign dly_done = s_q.cnt == 16'h0000;

  assign setup = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable;
  assign wr = access && apb_req.pwrite;
  // a running drive must not lose or gain its brake output
  assign locked = s_q.pwr && apb_req.paddr == OFF_CTRL;

  always_comb begin
    mapped = 1'b1;
    rd_data = 32'h00000000;
    unique case (apb_req.paddr)
      OFF_CTRL: rd_data = {30'h00000000, s_q.cont_en, s_q.func_en};
      OFF_CW_LIM: rd_data = {16'h0000, s_q.cw_lim};
      OFF_CCW_LIM: rd_data = {16'h0000, s_q.ccw_lim};
      OFF_HYS: rd_data = {16'h0000, s_q.hys};
      OFF_REL_DLY: rd_data = {16'h0000, s_q.rel_dly};
      OFF_APP_DLY: rd_data = {16'h0000, s_q.app_dly};
      OFF_CON_DLY: rd_data = {16'h0000, s_q.con_dly};
      OFF_STATUS: rd_data = {s_q.sp, 9'h000, s_q.st, s_q.dir_ccw, s_q.con, s_q.pwr, s_q.brake};
      default: mapped = 1'b0;
    endcase
  end

  assign apb_rsp.prdata = s_q.prdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = access && (!mapped || (apb_req.pwrite && locked));
  assign drive = '{s_q.brake, s_q.pwr, s_q.con, s_q.sp};

  always_comb begin
    s_d = s_q;
    // free-running ms divider, restarted when a delay is loaded
    s_d.tick = 1'b0;
    if (s_q.div == DIV_W'(CYCLES_PER_MS - 1)) begin
      s_d.div = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 17'h00001;
    end
    if (s_q.tick && !dly_done) begin
      s_d.cnt = s_q.cnt - 16'h0001;
    end
    if (setup) begin
      s_d.prdata = rd_data;
    end
    if (wr) begin
      unique case (apb_req.paddr)
        OFF_CTRL: begin
          if (!locked) begin
            s_d.func_en = apb_req.pwdata[CTRL_FUNC_BIT];
            s_d.cont_en = apb_req.pwdata[CTRL_CONT_BIT];
          end
        end
        OFF_CW_LIM: begin
          // out-of-range settings are clamped, not rejected
          if (apb_req.pwdata[15]) s_d.cw_lim = 16'h0000;
          else if (apb_req.pwdata[15:0] > LIM_MAX) s_d.cw_lim = LIM_MAX;
          else s_d.cw_lim = apb_req.pwdata[15:0];
        end
        OFF_CCW_LIM: begin
          if (!apb_req.pwdata[15]) s_d.ccw_lim = 16'h0000;
          else if (apb_req.pwdata[15:0] < LIM_MIN) s_d.ccw_lim = LIM_MIN;
          else s_d.ccw_lim = apb_req.pwdata[15:0];
        end
        OFF_HYS: begin
          if (apb_req.pwdata[15] || apb_req.pwdata[15:0] == 16'h0000) s_d.hys = HYS_MIN;
          else if (apb_req.pwdata[15:0] > LIM_MAX) s_d.hys = LIM_MAX;
          else s_d.hys = apb_req.pwdata[15:0];
        end
        OFF_REL_DLY: s_d.rel_dly = apb_req.pwdata[15:0];
        OFF_APP_DLY: s_d.app_dly = apb_req.pwdata[15:0];
        OFF_CON_DLY: s_d.con_dly = apb_req.pwdata[15:0];
        default: ;
      endcase
    end

    unique case (s_q.st)
      ST_IDLE: begin
        s_d.sp = speed_cmd;
        s_d.brake = 1'b0;
        if (!s_q.func_en) begin
          s_d.pwr = !cmd_zero;
        end else if (!cmd_zero) begin
          s_d.con = s_q.cont_en;
          s_d.cnt = s_q.cont_en ? s_q.con_dly : 16'h0000;
          s_d.div = '0;
          s_d.st = ST_CON_ON;
        end else begin
          s_d.pwr = 1'b0;
        end
      end
      ST_CON_ON: begin
        if (!s_q.func_en) begin
          s_d.st = ST_CON_OFF;
        end else if (dly_done) begin
          s_d.pwr = 1'b1;
          s_d.st = ST_LOW;
          s_d.sp = speed_cmd;
          if (exceed_cw || exceed_ccw) begin
            s_d.dir_ccw = exceed_ccw;
            s_d.sp = exceed_ccw ? s_q.ccw_lim : s_q.cw_lim;
            s_d.brake = 1'b1;
            s_d.cnt = s_q.rel_dly;
            s_d.div = '0;
            s_d.st = ST_RELEASE;
          end
        end
      end
      ST_LOW: begin
        s_d.sp = speed_cmd;
        if (exceed_cw || exceed_ccw) begin
          s_d.dir_ccw = exceed_ccw;
          s_d.sp = exceed_ccw ? s_q.ccw_lim : s_q.cw_lim;
          s_d.brake = 1'b1;
          s_d.cnt = s_q.rel_dly;
          s_d.div = '0;
          s_d.st = ST_RELEASE;
        end else if (cmd_zero) begin
          s_d.pwr = 1'b0;
          s_d.cnt = s_q.cont_en ? s_q.con_dly : 16'h0000;
          s_d.div = '0;
          s_d.st = ST_CON_OFF;
        end
      end
      ST_RELEASE: begin
        s_d.sp = lim;
        if (dly_done) begin
          s_d.sp = speed_cmd;
          s_d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        s_d.sp = speed_cmd;
        if (below) begin
          s_d.sp = lim;
          s_d.st = ST_DECEL;
        end
      end
      ST_DECEL: begin
        s_d.sp = lim;
        if (!below) begin
          s_d.sp = speed_cmd;
          s_d.st = ST_RUN;
        end else if (reached) begin
          s_d.brake = 1'b0;
          s_d.cnt = s_q.app_dly;
          s_d.div = '0;
          s_d.st = ST_APPLY;
        end
      end
      ST_APPLY: begin
        s_d.sp = lim;
        if (dly_done) begin
          s_d.sp = speed_cmd;
          s_d.st = ST_LOW;
          if (cmd_zero) begin
            s_d.pwr = 1'b0;
            s_d.cnt = s_q.cont_en ? s_q.con_dly : 16'h0000;
            s_d.div = '0;
            s_d.st = ST_CON_OFF;
          end
        end
      end
      ST_CON_OFF: begin
        s_d.sp = 16'h0000;
        if (dly_done) begin
          s_d.con = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
    endcase

    if (s_d.st != s_q.st) s_d.tick = 1'b0;
    if (fault) begin
      s_d.st = ST_IDLE;
      s_d.brake = 1'b0;
      s_d.pwr = 1'b0;
      s_d.con = 1'b0;
      s_d.sp = 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.cw_lim <= RST_CW_LIM;
      s_q.ccw_lim <= RST_CCW_LIM;
      s_q.hys <= RST_HYS;
      s_q.rel_dly <= RST_REL_DLY;
      s_q.app_dly <= RST_APP_DLY;
      s_q.con_dly <= RST_CON_DLY;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_fault_low;
    fault |=> !drive.brake_release && !drive.power_stage_en && !drive.contactor_on;
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("outputs not low after fault");
  property p_no_func;
    !s_q.func_en |-> !drive.brake_release;
  endproperty
  a_no_func: assert property (p_no_func) else $error("brake released without function");
  property p_release_at_lim;
    $rose(drive.brake_release) |-> drive.speed_setpoint == lim;
  endproperty
  a_release_at_lim: assert property (p_release_at_lim) else $error("release not at limit");
  property p_release_hold;
    s_q.st == ST_RELEASE && $past(s_q.st) == ST_RELEASE |-> drive.speed_setpoint == lim;
  endproperty
  a_release_hold: assert property (p_release_hold) else $error("setpoint left limit");
  property p_run_follow;
    s_q.st == ST_RUN && $past(s_q.st) == ST_RUN && !$past(fault)
      |-> drive.speed_setpoint == $past(speed_cmd);
  endproperty
  a_run_follow: assert property (p_run_follow) else $error("setpoint not following");
  property p_apply_hold;
    $fell(drive.brake_release) && !$past(fault) |-> drive.speed_setpoint == lim;
  endproperty
  a_apply_hold: assert property (p_apply_hold) else $error("apply not held at limit");
  property p_ctrl_locked;
    wr && s_q.pwr && apb_req.paddr == OFF_CTRL |=> $stable(s_q.func_en);
  endproperty
  a_ctrl_locked: assert property (p_ctrl_locked) else $error("function changed while on");

  property p_zero_delay;
    s_q.st == ST_RELEASE && s_q.cnt == 16'h0000 |=> s_q.st != ST_RELEASE;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay did not end");

  property p_off_brake;
    $fell(drive.power_stage_en) |-> !drive.brake_release;
  endproperty
  a_off_brake: assert property (p_off_brake) else $error("power off with brake open");

  c_release: cover property ($rose(drive.brake_release));
  c_apply: cover property (s_q.st == ST_APPLY ##1 s_q.st == ST_CON_OFF);
  c_fault_run: cover property (s_q.st == ST_RUN && fault);
  c_relock: cover property (s_q.st == ST_LOW ##1 s_q.st == ST_RELEASE);
endmodule

// ---- obs_brake_model.sv ----
`timescale 1ns/1ps
module obs_brake_model
  import obs_pkg::*;
#(
  parameter int REL_CYC = 20,
  parameter int APP_CYC = 10,
  parameter int STEP = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire obs_drive_t drive,
  output logic signed [15:0] speed_act,
  output logic brake_open
);
  int cnt;
  logic signed [15:0] sp;
  assign sp = drive.speed_setpoint;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_act <= '0;
      brake_open <= 1'b0;
      cnt <= 0;
    end else begin
      // the shoe lags the coil by its mechanical travel time
      if (drive.brake_release != brake_open) begin
        cnt <= cnt + 1;
        if (cnt >= (drive.brake_release ? REL_CYC : APP_CYC)) begin
          brake_open <= drive.brake_release;
          cnt <= 0;
        end
      end else begin
        cnt <= 0;
      end
      // open loop: slip lets the rotor follow even against a closed brake
      if (!drive.power_stage_en) begin
        speed_act <= '0;
      end else if (speed_act < sp - STEP) begin
        speed_act <= speed_act + 16'(STEP);
      end else if (speed_act > sp + STEP) begin
        speed_act <= speed_act - 16'(STEP);
      end else begin
        speed_act <= sp;
      end
    end
  end
endmodule

// ---- obs_brake_seq_tb_top.sv ----
`timescale 1ns/1ps
module obs_brake_seq_tb_top;
  import obs_pkg::*;
  localparam int CPM = 10;
  // slip speed of the modelled motor, rpm
  localparam logic [15:0] SLIP = 16'h005A;
  logic pclk, presetn, fault, brake_open, err;
  logic [15:0] speed_cmd, speed_act;
  logic [31:0] rd;
  obs_apb_req_t req;
  obs_apb_rsp_t rsp;
  obs_drive_t drive;
  int mismatches, compares;
  obs_brake_seq #(.CYCLES_PER_MS(CPM)) i_obs_brake_seq (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .speed_cmd(speed_cmd), .speed_act(speed_act),
    .fault(fault), .drive(drive));
  obs_brake_model i_obs_brake_model (.pclk(pclk), .presetn(presetn), .drive(drive),
    .speed_act(speed_act), .brake_open(brake_open));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    chk(rsp.pready === 1'b1, "no ready");
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge pclk);
  endtask
  function automatic logic pick(input int s);
    return s ? drive.power_stage_en : drive.brake_release;
  endfunction
  task automatic wait_bit(input int s, input logic v);
    int n = 0;
    while (pick(s) !== v && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk(pick(s) === v, "output wait");
  endtask
  task automatic hold(input logic [15:0] v, input int exp);
    int n = 0;
    while (drive.speed_setpoint === v && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk(n == exp, "hold length");
  endtask
  task automatic t_regs();
    logic [7:0] a[6] = '{OFF_CW_LIM, OFF_CCW_LIM, OFF_HYS, OFF_REL_DLY, OFF_APP_DLY, OFF_CON_DLY};
    logic [15:0] e[6] = '{RST_CW_LIM, RST_CCW_LIM, RST_HYS, RST_REL_DLY, RST_APP_DLY, RST_CON_DLY};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, a[i], '0);
      chk(rd === {16'h0000, e[i]}, "reset value");
    end
    apb(1'b0, 8'h20, '0);
    chk(err === 1'b1 && rd === '0, "unmapped");
    apb(1'b1, OFF_CW_LIM, 32'h0000_7FFF);
    apb(1'b0, OFF_CW_LIM, '0);
    chk(rd === 32'h0000_7FFC, "limit clamp");
    apb(1'b1, OFF_CCW_LIM, 32'h0000_8000);
    apb(1'b0, OFF_CCW_LIM, '0);
    chk(rd === {16'h0000, LIM_MIN}, "ccw clamp");
    apb(1'b1, OFF_HYS, 32'h0);
    apb(1'b0, OFF_HYS, '0);
    chk(rd === {16'h0000, HYS_MIN}, "hysteresis floor");
    apb(1'b1, OFF_CW_LIM, {16'h0000, SLIP});
    apb(1'b1, OFF_CCW_LIM, {16'h0000, -SLIP});
    apb(1'b1, OFF_HYS, {16'h0000, SLIP >> 1});
  endtask
  task automatic t_cw();
    int n = 0;
    logic ok = 1'b1;
    apb(1'b1, OFF_REL_DLY, 32'h2);
    apb(1'b1, OFF_APP_DLY, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h1);
    speed_cmd <= 16'h01F4;
    wait_bit(0, 1'b1);
    chk(drive.speed_setpoint === RST_CW_LIM, "release setpoint");
    hold(RST_CW_LIM, 2 * CPM + 2);
    chk(brake_open === 1'b1, "brake still shut");
    chk(drive.speed_setpoint === 16'h01F4, "resume setpoint");
    apb(1'b1, OFF_CTRL, 32'h0);
    chk(err === 1'b1, "ctrl write online");
    apb(1'b0, OFF_CTRL, '0);
    chk(rd[CTRL_FUNC_BIT] === 1'b1, "ctrl changed online");
    apb(1'b0, OFF_STATUS, '0);
    chk(rd === {16'h01F4, 9'h000, ST_RUN, 4'b0011}, "status word");
    speed_cmd <= 16'h0000;
    wait_bit(0, 1'b0);
    chk($signed(speed_act) <= $signed(RST_CW_LIM), "applied too fast");
    while (drive.power_stage_en === 1'b1 && n < 3000) begin
      if (drive.speed_setpoint !== RST_CW_LIM) ok = 1'b0;
      @(posedge pclk);
      n++;
    end
    chk(ok, "apply setpoint");
    chk(n == CPM + 2, "apply length");
    repeat (5) @(posedge pclk);
    chk(drive.brake_release === 1'b0, "brake reopened");
  endtask
  task automatic t_ccw();
    apb(1'b1, OFF_REL_DLY, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h3);
    speed_cmd <= 16'hFE0C;
    wait_bit(0, 1'b1);
    chk(drive.contactor_on === 1'b1, "contactor late");
    chk(drive.speed_setpoint === RST_CCW_LIM, "ccw setpoint");
    hold(RST_CCW_LIM, 1);
    chk(drive.speed_setpoint === 16'hFE0C, "ccw resume");
    fault <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(drive === '0, "fault outputs");
    fault <= 1'b0;
    speed_cmd <= 16'h0000;
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_hys();
    apb(1'b1, OFF_CTRL, 32'h1);
    speed_cmd <= 16'h0087;
    repeat (40) @(posedge pclk);
    chk(drive.brake_release === 1'b0, "hysteresis ignored");
    speed_cmd <= 16'h0088;
    wait_bit(0, 1'b1);
    speed_cmd <= 16'h0000;
    wait_bit(1, 1'b0);
  endtask
  task automatic t_nofunc();
    apb(1'b1, OFF_CTRL, 32'h0);
    chk(err === 1'b0, "ctrl write offline");
    speed_cmd <= 16'h012C;
    repeat (3) @(posedge pclk);
    chk(drive.speed_setpoint === 16'h012C, "plain setpoint");
    chk(drive.brake_release === 1'b0, "brake without function");
    speed_cmd <= 16'h0000;
  endtask
  initial begin
    req = '0;
    speed_cmd = '0;
    fault = 1'b0;
    presetn = 1'b0;
    mismatches = 0;
    compares = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_cw();
    t_ccw();
    t_hys();
    t_nofunc();
    conclude();
  end
  // whole run needs a few hundred cycles
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule
